/* File: prisl_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module prisl_chk (
    // Clock and reset.
    input  wire logic CLK_I,
    input  wire logic RESET_I,
    // Bus wires and enables.
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic scl_dev_oe_n,
    input  wire logic sda_dev_oe_n,
    input  wire logic scl_host_oe_n,
    input  wire logic sda_host_oe_n
);
    logic       scl_q;
    logic       sda_q;
    logic       rd_q;
    logic       hit_q;
    logic [3:0] bit_q;
    logic [3:0] byte_q;
    logic [7:0] sh_q;
    logic       rise_w;
    logic       start_w;
    logic       stop_w;
    logic       rd_w;

    assign rise_w  = scl & ~scl_q;
    assign start_w = scl & scl_q & sda_q & ~sda;
    assign stop_w  = scl & scl_q & ~sda_q & sda;
    assign rd_w    = (byte_q == 4'h0) ? sh_q[0] : rd_q;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_I) begin
        scl_q <= RESET_I | scl;
        sda_q <= RESET_I | sda;
    end

    // Bit and byte position since the last START.
    always_ff @(posedge CLK_I) begin
        if (RESET_I || start_w) begin
            bit_q  <= 4'h0;
            byte_q <= 4'h0;
        end else if (rise_w) begin
            bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
            if (bit_q == 4'h8 && byte_q != 4'hf) begin
                byte_q <= byte_q + 4'h1;
            end
        end
    end

    // Shifted byte, direction and whether the address was acknowledged.
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            sh_q  <= 8'h00;
            rd_q  <= 1'b0;
            hit_q <= 1'b0;
        end else if (rise_w && bit_q != 4'h8) begin
            sh_q <= {sh_q[6:0], sda};
        end else if (rise_w && byte_q == 4'h0) begin
            rd_q  <= sh_q[0];
            hit_q <= ~sda_dev_oe_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    property p_dev_scl_idle;
        scl_dev_oe_n;
    endproperty
    a_dev_scl_idle: assert property (p_dev_scl_idle)
        else $error("device pulled the clock line");

    property p_dev_sda_scl_low;
        $changed(sda_dev_oe_n) |-> !scl;
    endproperty
    a_dev_sda_scl_low: assert property (p_dev_sda_scl_low)
        else $error("device changed data while clock high");

    property p_ack_slot_only;
        rise_w && !sda_dev_oe_n && !(rd_q && byte_q != 4'h0) |-> bit_q == 4'h8;
    endproperty
    a_ack_slot_only: assert property (p_ack_slot_only)
        else $error("device pulled data outside the ninth clock");

    property p_read_ack_free;
        rise_w && rd_q && byte_q != 4'h0 && bit_q == 4'h8 |-> sda_dev_oe_n;
    endproperty
    a_read_ack_free: assert property (p_read_ack_free)
        else $error("device held data in the master acknowledge slot");

    property p_addr_ack;
        rise_w && bit_q == 4'h8 && byte_q == 4'h0 && sh_q[7:1] == prisl_pkg::SLAVE_ADDR
            |-> !sda_dev_oe_n;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("own address not acknowledged");

    property p_foreign_nack;
        rise_w && bit_q == 4'h8 && byte_q == 4'h0 && sh_q[7:1] != prisl_pkg::SLAVE_ADDR
            && sh_q[7:1] != prisl_pkg::GCALL_ADDR |-> sda_dev_oe_n;
    endproperty
    a_foreign_nack: assert property (p_foreign_nack)
        else $error("foreign address acknowledged");

    property p_write_ack;
        rise_w && bit_q == 4'h8 && byte_q != 4'h0 && hit_q && !rd_q |-> !sda_dev_oe_n;
    endproperty
    a_write_ack: assert property (p_write_ack)
        else $error("written byte not acknowledged");

    property p_stop_idle;
        stop_w |-> sda_dev_oe_n [*8];
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("device pulled data after STOP");

    property p_ack_release;
        rise_w && bit_q == 4'h8 && !sda_dev_oe_n && !rd_w |-> ##[1:40] sda_dev_oe_n;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("device did not release data after acknowledge");

    property p_host_scl_only;
        !scl |-> !scl_host_oe_n;
    endproperty
    a_host_scl_only: assert property (p_host_scl_only)
        else $error("clock line held low by someone other than the master");

    property p_host_ack_free;
        rise_w && bit_q == 4'h8 && (byte_q == 4'h0 || !rd_q) |-> sda_host_oe_n;
    endproperty
    a_host_ack_free: assert property (p_host_ack_free)
        else $error("master held data in the device acknowledge slot");
endmodule

`default_nettype wire

/* File: prisl_dev.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Answer slave address 0011000, and the general call when enabled.
// - Slave only; never drive the clock.
// - Bytes of eight bits, one clock each.
// - Data changes only while clock low.
// - Falling data is START, rising is STOP.
// - Master sends address and direction bit.
// - Acknowledge written bytes on ninth clock.
// - Master acknowledges read bytes; high means stop.
// - START while active restarts the transfer.
// - General call answered when enabled, off.
// - Further written bytes go to next register.
// - Acknowledged read sends next register.
// - Writable registers read back; status read-only.
// - Eight-bit registers, 128 per page.
// - Page 0 at reset; register 0 selects.
// - Page select takes any code 0..255.
// - Master uses only the usable pages.
// - Master keeps reserved bits at reset.
// - Software reset bit clears itself.
// - Overtemperature bit reads 0 when hot.
module prisl_dev (
    // Clock and reset.
    input  wire logic        CLK_I,
    input  wire logic        RESET_I,
    // Status from the amplifier, active high when overheated.
    input  wire logic        OVERTEMP_I,
    // Register state seen by the codec.
    output logic [7:0]       PAGE_O,
    output logic             GCALL_EN_O,
    output logic             SOFT_RESET_O,
    // Bus side.
    prisl_if.dev             bus
);
    typedef enum logic [2:0] {
        PRISLD_IDLE = 3'b000, PRISLD_ADDR = 3'b001, PRISLD_AACK = 3'b011,
        PRISLD_WBYTE = 3'b010, PRISLD_WACK = 3'b110, PRISLD_RBYTE = 3'b111,
        PRISLD_RACK = 3'b101
    } prisld_state_t;

    prisld_state_t state_q;
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [6:0] ptr_q;
    logic       ptr_ok_q;
    logic       gcall_q;
    logic [7:0] gctl_q;
    logic       ot_s1_q;
    logic       ot_q;
    logic [7:0] rd_data;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;
    logic       wr_en;
    logic       soft_rst;

    always_ff @(posedge CLK_I) begin
        scl_s_q <= {scl_s_q[0], bus.scl};
        sda_s_q <= {sda_s_q[0], bus.sda};
        scl_q   <= scl_s_q[1];
        sda_q   <= sda_s_q[1];
        ot_s1_q <= OVERTEMP_I;
        ot_q    <= ot_s1_q;
    end

    assign scl_rise = scl_s_q[1] & ~scl_q;
    assign scl_fall = ~scl_s_q[1] & scl_q;
    assign start_ev = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
    assign stop_ev  = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];

    // Data bytes after the pointer byte are written at the falling edge ending bit 8.
    assign wr_en    = (state_q == PRISLD_WBYTE) && ptr_ok_q && scl_fall
                      && (bit_q == 4'(prisl_pkg::BYTE_BITS)) && !gcall_q;
    assign soft_rst = SOFT_RESET_O;

    ////////////////////////////////////////////////////////////////////////////
    // Register file.
    // Page select exists on every page, the other control registers on page 0 only; other addresses read zero.

    always_comb begin
        rd_data = 8'h00;
        if (ptr_q == prisl_pkg::REG_PAGE_SELECT) rd_data = PAGE_O;
        else if (PAGE_O == 8'h00) begin
            unique case (ptr_q)
                prisl_pkg::REG_OVERTEMP:   rd_data = {6'h00, ~ot_q, 1'b0};
                prisl_pkg::REG_GCALL_CTRL: rd_data = gctl_q;
                default:                   rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I || soft_rst) begin
            PAGE_O <= prisl_pkg::PAGE_RESET;
            gctl_q <= prisl_pkg::GCALL_RESET;
        end else if (wr_en) begin
            if (ptr_q == prisl_pkg::REG_PAGE_SELECT) PAGE_O <= sh_q;
            else if (PAGE_O == 8'h00 && ptr_q == prisl_pkg::REG_GCALL_CTRL)
                gctl_q <= sh_q;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) GCALL_EN_O <= 1'b0;
        else GCALL_EN_O <= gctl_q[prisl_pkg::GCALL_EN_BIT];
    end

    // One-cycle pulse; the bit reads back as zero since it clears itself.
    always_ff @(posedge CLK_I) begin
        if (RESET_I) SOFT_RESET_O <= 1'b0;
        else SOFT_RESET_O <= wr_en && PAGE_O == 8'h00 && ptr_q == prisl_pkg::REG_SOFT_RESET
                             && sh_q[prisl_pkg::SOFT_RESET_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus protocol engine.

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            state_q <= PRISLD_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 7'h00;
            ptr_ok_q <= 1'b0;
            gcall_q <= 1'b0;
            bus.sda_dev_oe_n <= 1'b1;
        end else if (start_ev) begin
            state_q <= PRISLD_ADDR;
            bit_q <= 4'h0;
            bus.sda_dev_oe_n <= 1'b1;
        end else if (stop_ev) begin
            state_q <= PRISLD_IDLE;
            bus.sda_dev_oe_n <= 1'b1;
        end else begin
            unique case (state_q)
                PRISLD_IDLE: bus.sda_dev_oe_n <= 1'b1;
                PRISLD_ADDR, PRISLD_WBYTE: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_q};
                        bit_q <= bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == 4'(prisl_pkg::BYTE_BITS)) begin
                        bit_q <= 4'h0;
                        if (state_q == PRISLD_ADDR) begin
                            if (sh_q[7:1] == prisl_pkg::SLAVE_ADDR ||
                                (sh_q[7:1] == prisl_pkg::GCALL_ADDR && !sh_q[0]
                                 && gctl_q[prisl_pkg::GCALL_EN_BIT])) begin
                                gcall_q <= (sh_q[7:1] == prisl_pkg::GCALL_ADDR);
                                bus.sda_dev_oe_n <= 1'b0;
                                state_q <= PRISLD_AACK;
                                ptr_ok_q <= 1'b0;
                            end else begin
                                state_q <= PRISLD_IDLE;
                            end
                        end else begin
                            bus.sda_dev_oe_n <= 1'b0;
                            state_q <= PRISLD_WACK;
                            if (!ptr_ok_q) begin
                                ptr_q <= sh_q[6:0];
                                ptr_ok_q <= 1'b1;
                            end else begin
                                ptr_q <= ptr_q + 7'h01;
                            end
                        end
                    end
                end
                PRISLD_AACK, PRISLD_WACK: if (scl_fall) begin
                    if (state_q == PRISLD_AACK && sh_q[0]) begin
                        sh_q <= rd_data;
                        bus.sda_dev_oe_n <= rd_data[7];
                        bit_q <= 4'h1;
                        state_q <= PRISLD_RBYTE;
                    end else begin
                        bus.sda_dev_oe_n <= 1'b1;
                        state_q <= PRISLD_WBYTE;
                    end
                end
                PRISLD_RBYTE: if (scl_fall) begin
                    if (bit_q == 4'(prisl_pkg::BYTE_BITS)) begin
                        bus.sda_dev_oe_n <= 1'b1;
                        ptr_q <= ptr_q + 7'h01;
                        state_q <= PRISLD_RACK;
                    end else begin
                        bus.sda_dev_oe_n <= sh_q[7 - bit_q[2:0]];
                        bit_q <= bit_q + 4'h1;
                    end
                end
                PRISLD_RACK: begin
                    if (scl_rise) sh_q[0] <= sda_q;
                    if (scl_fall) begin
                        if (!sh_q[0]) begin
                            sh_q <= rd_data;
                            bus.sda_dev_oe_n <= rd_data[7];
                            bit_q <= 4'h1;
                            state_q <= PRISLD_RBYTE;
                        end else begin
                            state_q <= PRISLD_IDLE;
                        end
                    end
                end
                default: state_q <= PRISLD_IDLE;
            endcase
        end
    end

    // The clock line is never pulled by this end.
    always_ff @(posedge CLK_I) begin
        bus.scl_dev_oe_n <= 1'b1;
    end
endmodule

`default_nettype wire

/* File: prisl_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Bus master: one command runs START, address, pointer, data bytes and STOP; reads add a repeated START and address.
module prisl_host #(
    parameter int HALF = prisl_pkg::SCL_HALF_CYCLES
) (
    // Clock and reset.
    input  wire logic        CLK_I,
    input  wire logic        RESET_I,
    // Command port.
    input  wire logic        START_I,
    input  wire logic        READ_I,
    input  wire logic [6:0]  ADDR_I,
    input  wire logic [6:0]  REG_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic [3:0]  COUNT_I,
    output logic             BUSY_O,
    output logic             NACK_O,
    output logic [7:0]       RDATA_O,
    output logic             RVALID_O,
    output logic             WNEXT_O,
    // Bus side.
    prisl_if.host            bus
);
    // The tick counter is eight bits wide and each bit needs three phases.
    if (HALF < 4 || HALF > 256) begin : g_half_check
        $error("HALF out of range");
    end

    typedef enum logic [2:0] {
        PRISLH_IDLE = 3'b000, PRISLH_START = 3'b001, PRISLH_BYTE = 3'b011,
        PRISLH_ACK = 3'b010, PRISLH_STOP = 3'b110, PRISLH_RSTART = 3'b111
    } prislh_state_t;

    prislh_state_t state_q;
    logic [7:0]  tick_q;
    logic [1:0]  ph_q;
    logic [3:0]  bit_q;
    logic [7:0]  sh_q;
    logic [3:0]  left_q;
    logic [1:0]  stage_q;
    logic        rd_q;
    logic [6:0]  addr_q;
    logic [6:0]  reg_q;
    logic        sda_s1_q;
    logic        sda_s2_q;
    logic        tick;

    assign tick = (tick_q == 8'(HALF - 1));

    always_ff @(posedge CLK_I) begin
        sda_s1_q <= bus.sda;
        sda_s2_q <= sda_s1_q;
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I || state_q == PRISLH_IDLE || tick) tick_q <= 8'h00;
        else tick_q <= tick_q + 8'h01;
    end

    // Stage 0 device address, 1 pointer, 2 data; reads go through a repeated START.
    always_ff @(posedge CLK_I) begin
        RVALID_O <= 1'b0;
        WNEXT_O  <= 1'b0;
        if (RESET_I) begin
            state_q <= PRISLH_IDLE;
            bus.scl_host_oe_n <= 1'b1;
            bus.sda_host_oe_n <= 1'b1;
            BUSY_O <= 1'b0;
            NACK_O <= 1'b0;
            RDATA_O <= 8'h00;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            left_q <= 4'h0;
            stage_q <= 2'h0;
            rd_q <= 1'b0;
            addr_q <= 7'h00;
            reg_q <= 7'h00;
        end else begin
            unique case (state_q)
                PRISLH_IDLE: begin
                    if (START_I) begin
                        BUSY_O <= 1'b1;
                        NACK_O <= 1'b0;
                        rd_q <= READ_I;
                        addr_q <= ADDR_I;
                        reg_q <= REG_I;
                        left_q <= (COUNT_I == 4'h0) ? 4'h1 : COUNT_I;
                        stage_q <= 2'h0;
                        sh_q <= {ADDR_I, 1'b0};
                        ph_q <= 2'h0;
                        state_q <= PRISLH_START;
                    end
                end
                PRISLH_START, PRISLH_RSTART: if (tick) begin
                    // SDA falls while SCL high, then SCL goes low.
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        bus.sda_host_oe_n <= 1'b1;
                        bus.scl_host_oe_n <= 1'b1;
                    end else if (ph_q == 2'h1) begin
                        bus.sda_host_oe_n <= 1'b0;
                    end else begin
                        bus.scl_host_oe_n <= 1'b0;
                        bit_q <= 4'h0;
                        ph_q <= 2'h0;
                        state_q <= PRISLH_BYTE;
                    end
                end
                PRISLH_BYTE: if (tick) begin
                    // Data changes only while SCL is low.
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        bus.sda_host_oe_n <= (stage_q == 2'h2 && rd_q) ? 1'b1 : sh_q[7];
                    end else if (ph_q == 2'h1) begin
                        bus.scl_host_oe_n <= 1'b1;
                    end else begin
                        bus.scl_host_oe_n <= 1'b0;
                        sh_q <= {sh_q[6:0], sda_s2_q};
                        ph_q <= 2'h0;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'(prisl_pkg::BYTE_BITS - 1)) state_q <= PRISLH_ACK;
                    end
                end
                PRISLH_ACK: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        // Read: ack unless last byte.
                        bus.sda_host_oe_n <= (stage_q == 2'h2 && rd_q) ? (left_q == 4'h1) : 1'b1;
                        if (stage_q == 2'h2 && rd_q) RDATA_O <= sh_q;
                    end else if (ph_q == 2'h1) begin
                        bus.scl_host_oe_n <= 1'b1;
                    end else begin
                        bus.scl_host_oe_n <= 1'b0;
                        ph_q <= 2'h0;
                        bit_q <= 4'h0;
                        if (!(stage_q == 2'h2 && rd_q) && sda_s2_q) begin
                            NACK_O <= 1'b1;
                            state_q <= PRISLH_STOP;
                        end else if (stage_q == 2'h0) begin
                            stage_q <= (sh_q[0]) ? 2'h2 : 2'h1;
                            sh_q <= (sh_q[0]) ? 8'h00 : {1'b0, reg_q};
                            state_q <= PRISLH_BYTE;
                        end else if (stage_q == 2'h1) begin
                            // Pointer byte first, then data or repeated START.
                            if (rd_q) begin
                                sh_q <= {addr_q, 1'b1};
                                stage_q <= 2'h0;
                                state_q <= PRISLH_RSTART;
                            end else begin
                                stage_q <= 2'h2;
                                sh_q <= WDATA_I;
                                WNEXT_O <= 1'b1;
                                state_q <= PRISLH_BYTE;
                            end
                        end else begin
                            if (rd_q) RVALID_O <= 1'b1;
                            left_q <= left_q - 4'h1;
                            if (left_q == 4'h1) state_q <= PRISLH_STOP;
                            else begin
                                sh_q <= rd_q ? 8'h00 : WDATA_I;
                                if (!rd_q) WNEXT_O <= 1'b1;
                                state_q <= PRISLH_BYTE;
                            end
                        end
                    end
                end
                PRISLH_STOP: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        bus.sda_host_oe_n <= 1'b0;
                    end else if (ph_q == 2'h1) begin
                        bus.scl_host_oe_n <= 1'b1;
                    end else begin
                        bus.sda_host_oe_n <= 1'b1;
                        BUSY_O <= 1'b0;
                        ph_q <= 2'h0;
                        state_q <= PRISLH_IDLE;
                    end
                end
                default: state_q <= PRISLH_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

/* File: prisl_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Two open-drain wires; each party's enable is low while it pulls the wire low.
interface prisl_if;
    logic scl_dev_oe_n;
    logic sda_dev_oe_n;
    logic scl_host_oe_n;
    logic sda_host_oe_n;
    wire  scl;
    wire  sda;

    assign scl = scl_dev_oe_n & scl_host_oe_n;
    assign sda = sda_dev_oe_n & sda_host_oe_n;

    modport dev  (input scl, input sda, output scl_dev_oe_n, output sda_dev_oe_n);
    modport host (input scl, input sda, output scl_host_oe_n, output sda_host_oe_n);
endinterface

`default_nettype wire

/* File: prisl_pkg.sv */
package prisl_pkg;

    // Bus address and general call.
    localparam logic [6:0] SLAVE_ADDR      = 7'h18;
    localparam logic [6:0] GCALL_ADDR      = 7'h00;

    // Register offsets within a page.
    localparam logic [6:0] REG_PAGE_SELECT = 7'h00;
    localparam logic [6:0] REG_SOFT_RESET  = 7'h01;
    localparam logic [6:0] REG_RESERVED2   = 7'h02;
    localparam logic [6:0] REG_OVERTEMP    = 7'h03;
    localparam logic [6:0] REG_GCALL_CTRL  = 7'h22;

    // Field positions.
    localparam int SOFT_RESET_BIT          = 0;
    localparam int OVERTEMP_BIT            = 1;
    localparam int GCALL_EN_BIT            = 5;

    // Reset values.
    localparam logic [7:0] PAGE_RESET      = 8'h00;
    localparam logic [7:0] GCALL_RESET     = 8'h00;
    localparam logic [7:0] OVERTEMP_RESET  = 8'h02;

    // Bits per byte and master clock divider for the host end.
    localparam int BYTE_BITS               = 8;
    localparam int SCL_HALF_CYCLES         = 8;

endpackage

/* File: prisl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module prisl_tb_top;
    logic       clk, rst, start, rd, overtemp;
    logic       busy, nack, rvalid, wnext, soft_rst, gcall_en;
    logic [6:0] addr, rg;
    logic [7:0] wdata, rdata, page;
    logic [3:0] count;
    int         err_total, samples_checked, sr_pulses;
    logic [7:0] wq [$];
    logic [7:0] rq [$];

    prisl_if bus ();
    prisl_host u_prisl_host (.CLK_I(clk), .RESET_I(rst), .START_I(start), .READ_I(rd),
        .ADDR_I(addr), .REG_I(rg), .WDATA_I(wdata), .COUNT_I(count), .BUSY_O(busy),
        .NACK_O(nack), .RDATA_O(rdata), .RVALID_O(rvalid), .WNEXT_O(wnext), .bus(bus.host));
    prisl_dev u_prisl_dev (.CLK_I(clk), .RESET_I(rst), .OVERTEMP_I(overtemp), .PAGE_O(page),
        .GCALL_EN_O(gcall_en), .SOFT_RESET_O(soft_rst), .bus(bus.dev));
    prisl_chk u_prisl_chk (.CLK_I(clk), .RESET_I(rst), .scl(bus.scl), .sda(bus.sda),
        .scl_dev_oe_n(bus.scl_dev_oe_n), .sda_dev_oe_n(bus.sda_dev_oe_n),
        .scl_host_oe_n(bus.scl_host_oe_n), .sda_host_oe_n(bus.sda_host_oe_n));

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One host command; data bytes advance after each data request pulse has passed.
    task automatic xfer(input logic r, input logic [6:0] a, input logic [6:0] g, input int n);
        int   k;
        int   idx;
        logic prev;
        k = 0;
        idx = 0;
        prev = 1'b0;
        rq = {};
        @(negedge clk);
        rd = r;
        addr = a;
        rg = g;
        count = 4'(n);
        wdata = (wq.size() > 0) ? wq[0] : 8'h00;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        chk({7'h00, busy}, 8'h01, "busy after command");
        while (busy === 1'b1 && k < 8000) begin
            @(negedge clk);
            k++;
            if (prev && wnext === 1'b0 && idx + 1 < wq.size()) begin
                idx++;
            end
            prev = wnext;
            wdata = (wq.size() > 0) ? wq[idx] : 8'h00;
            if (rvalid === 1'b1) begin
                rq.push_back(rdata);
            end
            if (soft_rst === 1'b1) begin
                sr_pulses++;
            end
        end
        if (k >= 8000) begin
            err_total++;
            $display("CHECK FAILED at %0t: command never finished", $time);
        end
    endtask

    task automatic write_regs(input logic [6:0] a, input logic [6:0] g, input logic [7:0] d [$],
                              input logic exp_nack);
        wq = d;
        xfer(1'b0, a, g, d.size());
        chk({7'h00, nack}, {7'h00, exp_nack}, "write acknowledge");
    endtask

    task automatic read_regs(input logic [6:0] g, input logic [7:0] e [$]);
        wq = {};
        xfer(1'b1, prisl_pkg::SLAVE_ADDR, g, e.size());
        chk({7'h00, nack}, 8'h00, "read acknowledge");
        chk(8'(rq.size()), 8'(e.size()), "read byte count");
        foreach (e[i]) chk(rq[i], e[i], "read data");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_reset_state();
        chk(page, 8'h00, "page after reset");
        chk({7'h00, gcall_en}, 8'h00, "general call after reset");
        read_regs(7'h00, {8'h00, 8'h00});
        read_regs(7'h03, {8'h02});
    endtask

    task automatic s_foreign();
        logic [6:0] other [4];
        other = '{7'h19, 7'h08, 7'h58, prisl_pkg::GCALL_ADDR};
        foreach (other[i]) write_regs(other[i], 7'h00, {8'h05}, 1'b1);
        chk(page, 8'h00, "page after foreign traffic");
    endtask

    task automatic s_page();
        write_regs(prisl_pkg::SLAVE_ADDR, 7'h00, {8'h0d}, 1'b0);
        chk(page, 8'h0d, "usable page selected");
        read_regs(7'h00, {8'h0d});
        write_regs(prisl_pkg::SLAVE_ADDR, 7'h00, {8'h00}, 1'b0);
        chk(page, 8'h00, "page zero selected from another page");
    endtask

    task automatic s_autoinc();
        write_regs(prisl_pkg::SLAVE_ADDR, 7'h21, {8'h5a, 8'h20}, 1'b0);
        chk({7'h00, gcall_en}, 8'h01, "general call enabled");
        read_regs(7'h21, {8'h00, 8'h20});
        write_regs(prisl_pkg::GCALL_ADDR, 7'h00, {8'h07}, 1'b0);
        chk(page, 8'h00, "general call data not stored");
    endtask

    task automatic s_overtemp();
        overtemp = 1'b1;
        read_regs(7'h03, {8'h00});
        overtemp = 1'b0;
        read_regs(7'h03, {8'h02});
    endtask

    task automatic s_soft_reset();
        sr_pulses = 0;
        write_regs(prisl_pkg::SLAVE_ADDR, 7'h01, {8'h00}, 1'b0);
        chk(8'(sr_pulses), 8'h00, "no reset on zero");
        write_regs(prisl_pkg::SLAVE_ADDR, 7'h00, {8'h00, 8'h01}, 1'b0);
        chk(8'(sr_pulses), 8'h01, "one reset pulse");
        chk({7'h00, gcall_en}, 8'h00, "general call restored");
        read_regs(7'h01, {8'h00});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        start = 1'b0;
        rd = 1'b0;
        addr = 7'h00;
        rg = 7'h00;
        wdata = 8'h00;
        count = 4'h0;
        overtemp = 1'b0;
        err_total = 0;
        samples_checked = 0;
        sr_pulses = 0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        s_reset_state();
        s_foreign();
        s_page();
        s_autoinc();
        s_overtemp();
        s_soft_reset();
        give_verdict();
    end

    // Seventeen short commands need well under ninety thousand cycles.
    initial begin
        #900000;
        err_total++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        give_verdict();
    end
endmodule

`default_nettype wire
